// File: common/saop_params.svh
// Purpose: Named constants of the serial audio output port
// Assumes: Register byte address is four times the register index
// Notes:   Field positions are bit numbers inside the low byte or word
`ifndef SAOP_PARAMS_SVH
`define SAOP_PARAMS_SVH

// ----------------------------------------------------------------
// Register indices and byte addresses
// ----------------------------------------------------------------
`define SAOP_IDX_FORMAT   8'h05
`define SAOP_IDX_SPDIF    8'h06
`define SAOP_IDX_OPTIONS  8'h07
`define SAOP_IDX_CLKCTRL  8'h08
`define SAOP_IDX_STATUS   8'h09
`define SAOP_ADDR_LSB     2

// ----------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------
`define SAOP_FMT_HI       7
`define SAOP_FMT_LO       5
`define SAOP_WS_DIR       4
`define SAOP_BCLK_DIR     3
`define SAOP_SP_VALID     7
`define SAOP_SP_ON        6
`define SAOP_SP_ACC_HI    5
`define SAOP_SP_ACC_LO    4
`define SAOP_SP_CTL_HI    3
`define SAOP_SP_CTL_LO    0
`define SAOP_OPT_LEFTHI   7
`define SAOP_OPT_DESCR    6
`define SAOP_OPT_INTERP   5
`define SAOP_OPT_FLAGSRC  3
`define SAOP_OPT_DMUTE    2
`define SAOP_OPT_SPMUTE   1
`define SAOP_CK_DIV_HI    7
`define SAOP_CK_DIV_LO    0
`define SAOP_CK_GATE      8
`define SAOP_CK_WSINV     9
`define SAOP_CK_DINV      10

// ----------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------
`define SAOP_RST_BYTE     8'h00
`define SAOP_RST_CLKCTRL  11'h000

// ----------------------------------------------------------------
// Last bit index of each slot length
// ----------------------------------------------------------------
`define SAOP_SLOT16_LAST  6'd15
`define SAOP_SLOT24_LAST  6'd23
`define SAOP_SLOT32_LAST  6'd31

`endif

// File: common/saop_pkg.sv
// Purpose: Types shared by the serial audio output port
// Assumes: Used together with saop_params.svh
// Notes:   Format codes follow the three-bit format field
package saop_pkg;

  typedef enum logic [2:0] {
    SAOP_I2S_16  = 3'h0,
    SAOP_I2S_24  = 3'h1,
    SAOP_I2S_32  = 3'h2,
    SAOP_EIAJ_16 = 3'h3,
    SAOP_EIAJ_24 = 3'h4,
    SAOP_EIAJ_32 = 3'h5
  } saop_format_e;

  typedef logic [5:0] saop_bitcnt_t;

endpackage

// File: hw/saop_serial_audio_out.sv
// Purpose: Serial audio output port with APB register access
// Assumes: Decoded samples arrive on the clk domain; pins are asynchronous
// Notes:   Left word goes first; data changes on the falling bit-clock edge
`timescale 1ns/100ps
`include "saop_params.svh"

module saop_serial_audio_out
  import saop_pkg::*;
#(
  parameter int DIV_WIDTH = 8
) (
  // Clock and reset
  input  wire logic        clk,
  input  wire logic        resetn,
  // APB slave
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  // Sample stream from the decoder FIFO
  input  wire logic [15:0] sampleData,
  input  wire logic        sampleFlagLsb,
  input  wire logic        sampleFlagMsb,
  input  wire logic        sampleValid,
  output logic             sampleTake,
  input  wire logic        edcOk,
  // Bit clock pin
  input  wire logic        bitClockIn,
  output logic             bitClockOut,
  output logic             bitClockOe_n,
  // Word select pin
  input  wire logic        wordSelectIn,
  output logic             wordSelectOut,
  output logic             wordSelectOe_n,
  // Serial data and flag pins
  output logic             serialDataOut,
  output logic             flagOut,
  output logic             fifoEmptyStopClock,
  // Controls towards the IEC958 encoder and decoder core
  output logic             spdifOutputEnable,
  output logic             spdifDataValid,
  output logic             spdifDataMute,
  output logic [1:0]       spdifClockAccuracy,
  output logic [3:0]       spdifControlBits,
  output logic             descrambleEnable,
  output logic             interpolationEnable
);

  // ----------------------------------------------------------------
  // Register file
  // ----------------------------------------------------------------
  logic [7:0]  formatCtrl_q, spdifCtrl_q, options_q, regIdx;
  logic [10:0] clkCtrl_q;
  logic [31:0] prdata_q;
  logic        pready_q, pslverr_q, stop_q, idxOk, wrEn;

  assign regIdx = paddr[`SAOP_ADDR_LSB +: 8];
  // Upper address bits must be zero so no register aliases higher up
  assign idxOk  = (paddr[`SAOP_ADDR_LSB-1:0] == 2'h0) && (paddr[11:`SAOP_ADDR_LSB+8] == 2'h0) &&
                  (regIdx >= `SAOP_IDX_FORMAT) && (regIdx <= `SAOP_IDX_STATUS);
  assign wrEn   = psel && penable && pready_q && pwrite && idxOk;

  // Zero wait states: pready rises in the access phase after setup
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      pready_q  <= 1'b0;
      pslverr_q <= 1'b0;
      prdata_q  <= 32'h0;
    end else begin
      pready_q  <= psel && !penable;
      pslverr_q <= psel && !penable && !idxOk;
      if (psel && !penable) begin
        // Control registers are write only and read back as zero
        if (!pwrite && idxOk && regIdx == `SAOP_IDX_STATUS) begin
          prdata_q <= {30'h0, sampleValid, stop_q};
        end else begin
          prdata_q <= 32'h0;
        end
      end
    end
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      formatCtrl_q <= `SAOP_RST_BYTE;
      spdifCtrl_q  <= `SAOP_RST_BYTE;
      options_q    <= `SAOP_RST_BYTE;
      clkCtrl_q    <= `SAOP_RST_CLKCTRL;
    end else if (wrEn) begin
      case (regIdx)
        `SAOP_IDX_FORMAT:  formatCtrl_q <= {pwdata[7:3], 3'h0};
        `SAOP_IDX_SPDIF:   spdifCtrl_q  <= pwdata[7:0];
        `SAOP_IDX_OPTIONS: options_q    <= {pwdata[7:5], 1'b0, pwdata[3:1], 1'b0};
        `SAOP_IDX_CLKCTRL: clkCtrl_q    <= pwdata[10:0];
        default: ;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Decoded controls
  // ----------------------------------------------------------------
  logic [2:0]   fmtCode;
  logic         wsIsOut, bclkIsOut, eiaj;
  saop_bitcnt_t slotLast;

  assign fmtCode   = formatCtrl_q[`SAOP_FMT_HI:`SAOP_FMT_LO];
  assign wsIsOut   = formatCtrl_q[`SAOP_WS_DIR];
  assign bclkIsOut = formatCtrl_q[`SAOP_BCLK_DIR];

  always_comb begin
    // Codes above the six formats fall back to the first one
    eiaj = (fmtCode >= SAOP_EIAJ_16) && (fmtCode <= SAOP_EIAJ_32);
    case (saop_format_e'(fmtCode))
      SAOP_I2S_24, SAOP_EIAJ_24: slotLast = `SAOP_SLOT24_LAST;
      SAOP_I2S_32, SAOP_EIAJ_32: slotLast = `SAOP_SLOT32_LAST;
      default:                   slotLast = `SAOP_SLOT16_LAST;
    endcase
  end

  // ----------------------------------------------------------------
  // Pin synchronisers
  // ----------------------------------------------------------------
  logic [1:0] bclkSync_q, wsSync_q;
  logic       bclkPrev_q, wsPrev_q, tick;

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      bclkSync_q <= 2'h0;
      wsSync_q   <= 2'h0;
      bclkPrev_q <= 1'b0;
      wsPrev_q   <= 1'b0;
    end else begin
      bclkSync_q <= {bclkSync_q[0], bitClockIn};
      wsSync_q   <= {wsSync_q[0], wordSelectIn};
      bclkPrev_q <= bclkSync_q[1];
      if (tick) begin
        wsPrev_q <= wsSync_q[1];
      end
    end
  end

  // ----------------------------------------------------------------
  // Bit clock generation
  // ----------------------------------------------------------------
  logic [DIV_WIDTH-1:0] divCnt_q;
  logic                 bclkGen_q, genPause, genToggle;

  assign genPause  = clkCtrl_q[`SAOP_CK_GATE] && stop_q;
  assign genToggle = bclkIsOut && !genPause &&
                     (divCnt_q == clkCtrl_q[`SAOP_CK_DIV_HI:`SAOP_CK_DIV_LO]);

  // half period is the prescaler value plus one, in clk cycles
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      divCnt_q  <= '0;
      bclkGen_q <= 1'b0;
    end else if (!bclkIsOut || genPause || genToggle) begin
      divCnt_q  <= '0;
      if (genToggle) begin
        bclkGen_q <= !bclkGen_q;
      end
    end else begin
      divCnt_q  <= divCnt_q + 1'b1;
    end
  end

  // data advances on the falling edge
  // slave mode follows the synchronised input clock
  assign tick = bclkIsOut ? (genToggle && bclkGen_q)
                          : (bclkPrev_q && !bclkSync_q[1]);

  // ----------------------------------------------------------------
  // Word engine
  // ----------------------------------------------------------------
  logic [15:0]  word_q, holdL_q, holdR_q, srcWord;
  logic         flagLsb_q, flagMsb_q, prevLsb_q, rightCh_q, take_q;
  logic         atEnd, wsEdge, loadNow, nextRight;
  saop_bitcnt_t bitCnt_q;

  // A format change can leave the count past the new slot end
  assign atEnd    = (bitCnt_q >= slotLast);
  // Slave word select restarts the slot on each change
  assign wsEdge   = !wsIsOut && (wsSync_q[1] != wsPrev_q);
  assign loadNow  = tick && (atEnd || wsEdge) && sampleValid;
  assign nextRight = wsEdge ? (wsSync_q[1] ^ !options_q[`SAOP_OPT_LEFTHI] ^
                               clkCtrl_q[`SAOP_CK_WSINV] ^ 1'b1) : !rightCh_q;

  // unreliable words repeat the last good sample of the channel
  always_comb begin
    srcWord = sampleData;
    if (options_q[`SAOP_OPT_INTERP] && (sampleFlagLsb || sampleFlagMsb)) begin
      srcWord = nextRight ? holdR_q : holdL_q;
    end
  end

  // stop indication follows underflow at the word boundary
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      stop_q <= 1'b0;
    end else if (tick && (atEnd || wsEdge) && !sampleValid) begin
      stop_q <= 1'b1;
    end else if (sampleValid) begin
      stop_q <= 1'b0;
    end
  end

  // one word per slot of 16, 24 or 32 bit clocks
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      bitCnt_q  <= '0;
      rightCh_q <= 1'b1;
      word_q    <= 16'h0;
      flagLsb_q <= 1'b0;
      flagMsb_q <= 1'b0;
      prevLsb_q <= 1'b0;
      take_q    <= 1'b0;
    end else begin
      take_q <= loadNow;
      if (loadNow) begin
        bitCnt_q  <= '0;
        rightCh_q <= nextRight;
        word_q    <= srcWord;
        flagLsb_q <= sampleFlagLsb;
        flagMsb_q <= sampleFlagMsb;
        prevLsb_q <= word_q[0];
      end else if (tick && !atEnd && !wsEdge) begin
        bitCnt_q  <= bitCnt_q + 6'd1;
      end
    end
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      holdL_q <= 16'h0;
      holdR_q <= 16'h0;
    end else if (loadNow && !sampleFlagLsb && !sampleFlagMsb) begin
      if (nextRight) begin
        holdR_q <= sampleData;
      end else begin
        holdL_q <= sampleData;
      end
    end
  end

  // ----------------------------------------------------------------
  // Serial bit selection
  // ----------------------------------------------------------------
  saop_bitcnt_t nextCnt;
  logic [15:0]  curWord;
  logic         curLsb, dataBit, inMsbHalf;
  logic [4:0]   pos;

  assign nextCnt = loadNow ? 6'd0 : (atEnd ? bitCnt_q : bitCnt_q + 6'd1);
  assign curWord = loadNow ? srcWord : word_q;
  assign curLsb  = loadNow ? word_q[0] : prevLsb_q;

  // I2S lags word select by one bit, EIAJ is right aligned
  always_comb begin
    dataBit   = 1'b0;
    inMsbHalf = 1'b0;
    pos       = 5'h0;
    if (eiaj) begin
      if (nextCnt + 6'd16 > slotLast) begin
        pos       = 5'(nextCnt + 6'd15 - slotLast);
        dataBit   = curWord[4'(5'd15 - pos)];
        inMsbHalf = pos < 5'd8;
      end
    end else if (nextCnt == 6'd0) begin
      dataBit = (slotLast == 6'd15) ? curLsb : 1'b0;
    end else if (nextCnt <= 6'd16) begin
      pos       = 5'(nextCnt - 6'd1);
      dataBit   = curWord[4'(5'd15 - pos)];
      inMsbHalf = pos < 5'd8;
    end
  end

  // ----------------------------------------------------------------
  // Output pins
  // ----------------------------------------------------------------
  logic dataPin_q, flag_pin_source_q, wsPin_q, bclkPin_q, bclkOe_q, wsOe_q;

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      dataPin_q <= 1'b0;
      flag_pin_source_q <= 1'b0;
      wsPin_q   <= 1'b0;
    end else if (tick) begin
      dataPin_q <= (dataBit && !options_q[`SAOP_OPT_DMUTE]) ^ clkCtrl_q[`SAOP_CK_DINV];
      // flag of the half being shifted
      flag_pin_source_q <= options_q[`SAOP_OPT_FLAGSRC] ?
                   (inMsbHalf ? (loadNow ? sampleFlagMsb : flagMsb_q) : flagLsb_q) : edcOk;
      wsPin_q   <= (loadNow ? nextRight : rightCh_q) ^ options_q[`SAOP_OPT_LEFTHI] ^
                   clkCtrl_q[`SAOP_CK_WSINV];
    end
  end

  // pins driven only in master mode
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      bclkPin_q <= 1'b0;
      bclkOe_q  <= 1'b1;
      wsOe_q    <= 1'b1;
    end else begin
      // Pin falls on the edge that moves data, never after it
      bclkPin_q <= bclkGen_q ^ genToggle;
      bclkOe_q  <= !bclkIsOut;
      wsOe_q    <= !wsIsOut;
    end
  end

  // ----------------------------------------------------------------
  // Control outputs
  // ----------------------------------------------------------------
  logic [9:0] ctlOut_q;

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      ctlOut_q <= 10'h0;
    end else begin
      ctlOut_q <= {spdifCtrl_q[`SAOP_SP_VALID], spdifCtrl_q[`SAOP_SP_ON],
                   spdifCtrl_q[`SAOP_SP_ACC_HI:`SAOP_SP_ACC_LO],
                   spdifCtrl_q[`SAOP_SP_CTL_HI:`SAOP_SP_CTL_LO],
                   options_q[`SAOP_OPT_SPMUTE], options_q[`SAOP_OPT_DESCR]};
    end
  end

  assign prdata              = prdata_q;
  assign pready              = pready_q;
  assign pslverr             = pslverr_q;
  assign sampleTake          = take_q;
  assign bitClockOut         = bclkPin_q;
  assign bitClockOe_n        = bclkOe_q;
  assign wordSelectOut       = wsPin_q;
  assign wordSelectOe_n      = wsOe_q;
  assign serialDataOut       = dataPin_q;
  assign flagOut             = flag_pin_source_q;
  assign fifoEmptyStopClock  = stop_q;
  assign spdifDataValid      = ctlOut_q[9];
  assign spdifOutputEnable   = ctlOut_q[8];
  assign spdifClockAccuracy  = ctlOut_q[7:6];
  assign spdifControlBits    = ctlOut_q[5:2];
  assign spdifDataMute       = ctlOut_q[1];
  assign descrambleEnable    = ctlOut_q[0];
  assign interpolationEnable = options_q[`SAOP_OPT_INTERP];

endmodule

// File: tb/saop_serial_audio_out_assertions.sv
// Purpose: Port-level checks of the serial audio output port
// Assumes: Gate enable is set whenever the bit clock pin is driven
// Notes:   Sees only top-level ports, attached by bind
`timescale 1ns/100ps

module saop_sao_checker (
  // Clock and reset
  input wire logic        clk,
  input wire logic        resetn,
  // APB
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] prdata,
  input wire logic        pready,
  input wire logic        pslverr,
  // Stream and pins
  input wire logic        sampleValid,
  input wire logic        sampleTake,
  input wire logic        bitClockOut,
  input wire logic        bitClockOe_n,
  input wire logic        wordSelectOut,
  input wire logic        wordSelectOe_n,
  input wire logic        fifoEmptyStopClock
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!resetn);

  // ----------------------------------------------------------------
  // Register access
  // ----------------------------------------------------------------
  a_apb_zero_wait: assert property (
    psel && penable |-> pready) else $error("access phase without ready");
  a_apb_bad_addr: assert property (
    psel && penable && (paddr < 12'h014 || paddr > 12'h024 || paddr[1:0] != 2'h0)
    |-> pslverr) else $error("unmapped access not refused");
  a_wo_read_zero: assert property (
    psel && penable && !pwrite && paddr != 12'h024 |-> prdata == 32'h0)
    else $error("write-only register read not zero");

  // ----------------------------------------------------------------
  // Stream and stop-clock
  // ----------------------------------------------------------------
  a_take_one_cycle: assert property (
    sampleTake |=> !sampleTake) else $error("take longer than a cycle");
  a_take_needs_valid: assert property (
    sampleTake |-> $past(sampleValid)) else $error("word taken without valid");
  a_stop_on_empty: assert property (
    $rose(fifoEmptyStopClock) |-> !$past(sampleValid)) else $error("stop while data present");
  a_stop_clears: assert property (
    fifoEmptyStopClock && sampleValid |=> !fifoEmptyStopClock) else $error("stop stuck");
  // Gated master clock must freeze low during underflow
  a_gate_freeze: assert property (
    (fifoEmptyStopClock && !bitClockOe_n) [*3] |-> !bitClockOut)
    else $error("bit clock runs during underflow");
  a_ws_on_fall: assert property (
    !wordSelectOe_n && !bitClockOe_n && $changed(wordSelectOut) |-> !bitClockOut)
    else $error("word select moved with bit clock high");
endmodule

bind saop_serial_audio_out saop_sao_checker u_saop_sao_checker (
  .clk, .resetn, .psel, .penable, .pwrite, .paddr, .prdata, .pready, .pslverr,
  .sampleValid, .sampleTake, .bitClockOut, .bitClockOe_n, .wordSelectOut,
  .wordSelectOe_n, .fifoEmptyStopClock
);

// File: tb/saop_dac_model.sv
// Purpose: Receiver at the far end of the serial link, optional clock source
// Assumes: Bit period at least 16 clk in slave mode so synced pins settle
// Notes:   Captures data on rising bit-clock edges, measures slot length
`timescale 1ns/100ps

module saop_dac_model (
  // Clock and bench control
  input  wire logic        clk,
  input  wire logic        slaveRun,
  // Port pins
  input  wire logic        bitClockOut,
  input  wire logic        wordSelectOut,
  input  wire logic        serialDataOut,
  input  wire logic        fifoEmptyStopClock,
  output logic             bitClockIn = 1'b0,
  output logic             wordSelectIn = 1'b0,
  // Observations
  output logic [15:0]      lastWord,
  output logic [5:0]       slotLen
);
  logic        bPrev = 1'b0;
  logic        wsPrev = 1'b0;
  logic [15:0] shiftQ = 16'h0;
  logic [5:0]  bitCnt = 6'h0;
  logic [2:0]  genCnt = 3'h0;
  logic [3:0]  genBits = 4'h0;
  wire  logic  bclk = slaveRun ? bitClockIn : bitClockOut;
  wire  logic  ws = slaveRun ? wordSelectIn : wordSelectOut;

  always_ff @(posedge clk) begin
    bPrev <= bclk;
    if (bclk && !bPrev) begin
      wsPrev <= ws;
      shiftQ <= {shiftQ[14:0], serialDataOut};
      bitCnt <= bitCnt + 6'h01;
      if (ws != wsPrev) begin
        lastWord <= shiftQ;
        slotLen <= bitCnt;
        bitCnt <= 6'h01;
      end
    end
  end

  // slave clocks, halted low during underflow
  always_ff @(posedge clk) begin
    if (!slaveRun) begin
      genCnt <= 3'h0;
      genBits <= 4'h0;
      wordSelectIn <= ~wordSelectIn;
    end else if (!(fifoEmptyStopClock && !bitClockIn)) begin
      genCnt <= genCnt + 3'h1;
      if (genCnt == 3'h7) begin
        bitClockIn <= ~bitClockIn;
        if (bitClockIn) begin
          genBits <= genBits + 4'h1;
          if (genBits == 4'hf) wordSelectIn <= ~wordSelectIn;
        end
      end
    end
  end
endmodule

// File: tb/saop_serial_audio_out_tb.sv
// Purpose: Self-checking bench of the serial audio output port
// Assumes: Zero-wait APB slave; constant sample stream from the bench
// Notes:   Divider 1 keeps master words short
`timescale 1ns/100ps
`include "saop_params.svh"

module saop_serial_audio_out_tb
  import saop_pkg::*;
;
  localparam logic [11:0] A_FMT = 12'(`SAOP_IDX_FORMAT) << `SAOP_ADDR_LSB;
  localparam logic [11:0] A_SPD = 12'(`SAOP_IDX_SPDIF) << `SAOP_ADDR_LSB;
  localparam logic [11:0] A_OPT = 12'(`SAOP_IDX_OPTIONS) << `SAOP_ADDR_LSB;
  localparam logic [11:0] A_CLK = 12'(`SAOP_IDX_CLKCTRL) << `SAOP_ADDR_LSB;
  localparam logic [11:0] A_STA = 12'(`SAOP_IDX_STATUS) << `SAOP_ADDR_LSB;
  logic        clk, resetn, psel, penable, pwrite, pready, pslverr, er;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic [15:0] sampleData, lastWord;
  logic        sampleFlagLsb, sampleFlagMsb, sampleValid, sampleTake, edcOk, slaveRun;
  logic        bitClockIn, bitClockOut, bitClockOe_n, wordSelectIn, wordSelectOut;
  logic        wordSelectOe_n, serialDataOut, flagOut, fifoEmptyStopClock, b;
  logic        spdifOutputEnable, spdifDataValid, spdifDataMute, descrambleEnable;
  logic        interpolationEnable;
  logic [1:0]  spdifClockAccuracy;
  logic [3:0]  spdifControlBits;
  logic [5:0]  slotLen;
  int          bad_count = 0, check_count = 0, takeCount = 0, t0;

  saop_serial_audio_out u_saop_serial_audio_out (
    .clk, .resetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr,
    .sampleData, .sampleFlagLsb, .sampleFlagMsb, .sampleValid, .sampleTake, .edcOk,
    .bitClockIn, .bitClockOut, .bitClockOe_n, .wordSelectIn, .wordSelectOut,
    .wordSelectOe_n, .serialDataOut, .flagOut, .fifoEmptyStopClock, .spdifOutputEnable,
    .spdifDataValid, .spdifDataMute, .spdifClockAccuracy, .spdifControlBits,
    .descrambleEnable, .interpolationEnable
  );
  saop_dac_model u_saop_dac_model (
    .clk, .slaveRun, .bitClockOut, .wordSelectOut, .serialDataOut, .fifoEmptyStopClock,
    .bitClockIn, .wordSelectIn, .lastWord, .slotLen
  );

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end
  always @(posedge clk) if (sampleTake === 1'b1) takeCount <= takeCount + 1;

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp) begin
      bad_count++;
      $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  // Idle edge first so psel is never driven twice in one step
  task automatic acc(input logic wr, input logic [11:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge clk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    do begin
      @(posedge clk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    if (n >= 20) bad_count++;
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic wait_stop();
    for (int n = 0; n < 600 && fifoEmptyStopClock !== 1'b1; n++) @(posedge clk);
  endtask

  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", check_count, bad_count);
    if (bad_count == 0 && check_count > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask

  initial begin
    #1000000;
    bad_count++;
    tally_and_finish();
  end

  // ----------------------------------------------------------------
  // Tests
  // ----------------------------------------------------------------
  initial begin
    resetn = 1'b0; psel = 1'b0; penable = 1'b0; pwrite = 1'b0; paddr = 12'h000;
    pwdata = 32'h0; sampleData = 16'ha5c3; sampleFlagLsb = 1'b0; sampleFlagMsb = 1'b0;
    sampleValid = 1'b1; edcOk = 1'b0; slaveRun = 1'b0;
    repeat (6) @(posedge clk);
    chk(32'({bitClockOe_n, wordSelectOe_n}), 32'h3);
    resetn <= 1'b1;
    for (int i = 0; i < 2; i++) begin
      acc(1'b1, A_SPD, (i == 0) ? 32'ha5 : 32'h5a);
      repeat (3) @(posedge clk);
      chk(32'({spdifDataValid, spdifOutputEnable, spdifClockAccuracy, spdifControlBits}),
          (i == 0) ? 32'ha5 : 32'h5a);
    end
    acc(1'b1, A_OPT, 32'h62);
    repeat (3) @(posedge clk);
    chk(32'({descrambleEnable, interpolationEnable, spdifDataMute}), 32'h7);
    acc(1'b1, A_OPT, 32'h11);
    repeat (3) @(posedge clk);
    chk(32'({descrambleEnable, interpolationEnable, spdifDataMute}), 32'h0);
    acc(1'b0, A_FMT, 32'h0);
    chk({rd[30:0], er}, 32'h0);
    acc(1'b0, 12'h040, 32'h0);
    chk(32'(er), 32'h1);
    acc(1'b0, 12'h015, 32'h0);
    chk(32'(er), 32'h1);
    acc(1'b0, A_STA, 32'h0);
    chk(rd, 32'h2);
    acc(1'b1, A_CLK, 32'h101);
    acc(1'b1, A_FMT, 32'({SAOP_EIAJ_16, 5'h18}));
    repeat (2) @(posedge clk);
    chk(32'({bitClockOe_n, wordSelectOe_n}), 32'h0);
    for (int f = 0; f < 6; f++) begin
      acc(1'b1, A_FMT, 32'({f[2:0], 5'h18}));
      repeat (600) @(posedge clk);
      chk(32'(slotLen), 32'(16 + 8 * (f % 3)));
    end
    acc(1'b1, A_FMT, 32'({SAOP_EIAJ_16, 5'h18}));
    repeat (600) @(posedge clk);
    chk(32'(lastWord), 32'ha5c3);
    acc(1'b1, A_OPT, 32'h04);
    repeat (600) @(posedge clk);
    chk(32'(lastWord), 32'h0);
    acc(1'b1, A_CLK, 32'h501);
    repeat (600) @(posedge clk);
    chk(32'(lastWord), 32'hffff);
    acc(1'b1, A_CLK, 32'h101);
    for (int k = 0; k < 2; k++) begin
      acc(1'b1, A_OPT, (k == 0) ? 32'h80 : 32'h00);
      repeat (3) @(posedge clk);
      @(posedge clk iff sampleTake === 1'b1);
      // Left word comes first after reset, so an even count of earlier takes means left
      chk(32'(wordSelectOut), 32'(takeCount[0] ^ (k == 0)));
    end
    repeat (300) @(posedge clk);
    chk(32'(flagOut), 32'h0);
    sampleFlagMsb <= 1'b1;
    acc(1'b1, A_OPT, 32'h08);
    repeat (3) @(posedge clk);
    @(posedge clk iff sampleTake === 1'b1);
    chk(32'(flagOut), 32'h1);
    repeat (40) @(posedge clk);
    chk(32'(flagOut), 32'h0);
    sampleData <= 16'h1234;
    acc(1'b1, A_OPT, 32'h20);
    repeat (300) @(posedge clk);
    chk(32'(lastWord), 32'ha5c3);
    sampleValid <= 1'b0;
    wait_stop();
    chk(32'(fifoEmptyStopClock), 32'h1);
    repeat (3) @(posedge clk);
    b = bitClockOut;
    repeat (20) @(posedge clk);
    chk(32'(bitClockOut), 32'(b));
    sampleValid <= 1'b1;
    repeat (3) @(posedge clk);
    chk(32'(fifoEmptyStopClock), 32'h0);
    acc(1'b1, A_FMT, 32'({SAOP_EIAJ_16, 5'h00}));
    slaveRun <= 1'b1;
    repeat (3) @(posedge clk);
    chk(32'({bitClockOe_n, wordSelectOe_n}), 32'h3);
    t0 = takeCount;
    repeat (1000) @(posedge clk);
    chk(32'(takeCount > t0 + 1), 32'h1);
    sampleValid <= 1'b0;
    wait_stop();
    chk(32'(fifoEmptyStopClock), 32'h1);
    repeat (50) @(posedge clk);
    sampleValid <= 1'b1;
    repeat (3) @(posedge clk);
    chk(32'(fifoEmptyStopClock), 32'h0);
    tally_and_finish();
  end
endmodule
